// >>> core/asc_setup_ctrl.sv
// setup-byte decode, clock-mode and reference-mode control of the adc
// assumes serial pins and the start pin are asynchronous to clock, and
// scan_done comes from converter logic on clock
`timescale 1ns/1ps
`include "asc_consts.svh"

// Functional notes
// - bits 7:6 = 01 mark a setup write
// - decode clock, reference, pair-select fields
// - upper clock-mode bit resets to one
// - mode 01: internal clock, start-pin timed acquisition
// - mode 11: serial clock converts, pin analog
// - modes 00-10 count internal clock ticks
// - ref 00: internal for adc and dac
// - ref x0: off after scan, 218 wake
// - temperature: power reference, wait 244 cycles
// - ref 01/11: external, second pin reference
// - ref 10 default: internal adc, external dac
// - mode 11: 218 wake in serial clocks
// - mode 11: temperature waits 244 serial clocks
// - mode 11: result after 188 more clocks
// - low setup bits pick pair register
// - select 10/11 routes next byte there
// - modes 1x start on conversion write
module asc_setup_ctrl #(
   parameter int INT_DIV = 4                  // clock cycles per conv tick
) (
   input  wire logic       clock,             // system clock, 125 MHz
   input  wire logic       rst_n,             // async reset, active low
   input  wire logic       sclk_pin,          // serial clock pin
   input  wire logic       cs_n_pin,          // chip select pin, low active
   input  wire logic       mosi_pin,          // serial data in pin
   input  wire logic       conv_start_pin,    // conversion-start pin
   input  wire logic       scan_done,         // converter finished a scan
   output logic [1:0]      clk_mode_q,        // clock-mode field
   output logic [1:0]      ref_mode_q,        // reference-mode field
   output logic [1:0]      pair_sel_q,        // pair-register select field
   output logic [7:0]      unipolar_q,        // unipolar-mode pair register
   output logic [7:0]      bipolar_q,         // bipolar-mode pair register
   output logic            conv_clk_ext_q,    // conversion clock from sclk
   output logic            acq_by_pin_q,      // acquisition timed by pin
   output logic            acq_by_sclk_q,     // sampling timed by sclk
   output logic            start_pin_analog_q,// shared start pin is analog
   output logic            second_ref_pin_analog_q,     // second ref pin is analog
   output logic            adc_int_ref_q,     // adc uses internal reference
   output logic            dac_int_ref_q,     // dac uses internal reference
   output logic            int_ref_pwr_q,     // internal reference powered
   output logic            conv_go_q,         // pulse: begin analog scan
   output logic            temp_go_q,         // pulse: temperature result
   output logic            busy_q             // scan sequence in progress
);

   logic [3:0] s1_q;                          // first sync stage
   logic [3:0] s2_q;                          // second sync stage
   logic       sclk_s3_q;                     // sclk history for edges
   logic       cvst_s3_q;                     // start pin history
   logic [2:0] bit_q;                         // bit count within byte
   logic [6:0] sh_q;                          // received bits so far
   logic       exp_q;                         // next byte is pair data
   logic [7:0] div_q;                         // internal clock divider
   logic       int_tick_q;                    // internal conversion tick
   logic       temp_req_q;                    // pending temperature ask
   logic [7:0] hlp_q;                         // ticks seen in this state
   asc_pkg::asc_state_t st_q;                 // sequencer state
   asc_pkg::asc_state_t st_d;                 // sequencer next state
   logic       ld;                            // timer load strobe
   logic [7:0] ld_val;                        // timer load value
   logic       expired;                       // timer finished

   localparam logic [7:0] DIV_LAST = 8'(INT_DIV - 1); // divider wrap

   // synchronised pins
   wire logic sclk_s = s2_q[0];
   wire logic cs_n_s = s2_q[1];
   wire logic mosi_s = s2_q[2];
   wire logic cvst_s = s2_q[3];
   wire logic sclk_rise = sclk_s & ~sclk_s3_q;
   wire logic cvst_fall = ~cvst_s & cvst_s3_q;
   wire logic [7:0] rx_byte = {sh_q, mosi_s};
   wire logic byte_done = sclk_rise & ~cs_n_s & (bit_q == 3'h7);
   wire logic is_setup = ~exp_q
      & (rx_byte[7:6] == `ASC_SEL_SETUP);
   wire logic is_conv = ~exp_q & rx_byte[`ASC_CONV_SEL];
   wire logic ext_mode = (clk_mode_q == `ASC_MODE_EXT);
   // conversion tick: serial clock edges in mode 11, else internal
   wire logic tick = ext_mode ? sclk_rise : int_tick_q;
   wire logic reg_start = byte_done & is_conv & clk_mode_q[1];
   wire logic pin_start = cvst_fall & ~clk_mode_q[1];
   wire logic scan_req = reg_start | pin_start;
   wire logic temp_now = (byte_done & is_conv) ?
      rx_byte[`ASC_TEMP_BIT] : temp_req_q;

   // two-flop synchronisers, then edge history from stage two
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1_q      <= 4'hB;                   // idle: cs, sclk, pin high
         s2_q      <= 4'hB;
         sclk_s3_q <= 1'b1;
         cvst_s3_q <= 1'b1;
      end else begin
         s1_q      <= {conv_start_pin, mosi_pin, cs_n_pin, sclk_pin};
         s2_q      <= s1_q;
         sclk_s3_q <= sclk_s;
         cvst_s3_q <= cvst_s;
      end
   end

   // serial byte assembly, msb first on rising sclk
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bit_q <= 3'h0;
         sh_q  <= 7'h00;
         exp_q <= 1'b0;
      end else if (cs_n_s) begin
         bit_q <= 3'h0;                       // frame ends, realign
         exp_q <= 1'b0;
      end else if (sclk_rise) begin
         bit_q <= 3'(bit_q + 3'h1);
         sh_q  <= rx_byte[6:0];
         if (byte_done) begin
            // data byte follows only for select 10 or 11
            exp_q <= is_setup & rx_byte[`ASC_PAIR_HI];
         end
      end
   end

   // setup register fields
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         clk_mode_q <= `ASC_CLK_MODE_RST;
         ref_mode_q <= `ASC_REF_MODE_RST;
         pair_sel_q <= `ASC_PAIR_RST;
      end else if (byte_done && is_setup) begin
         clk_mode_q <= rx_byte[`ASC_CLK_HI:`ASC_CLK_LO];
         ref_mode_q <= rx_byte[`ASC_REF_HI:`ASC_REF_LO];
         pair_sel_q <= rx_byte[`ASC_PAIR_HI:`ASC_PAIR_LO];
      end
   end

   // pair registers loaded by the byte after the setup byte
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         unipolar_q <= `ASC_PAIR_REG_RST;
         bipolar_q  <= `ASC_PAIR_REG_RST;
      end else if (byte_done && exp_q) begin
         if (pair_sel_q == `ASC_PAIR_UNI) begin
            unipolar_q <= rx_byte;
         end else begin
            bipolar_q  <= rx_byte;
         end
      end
   end

   // pin and source configuration from the mode fields
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         conv_clk_ext_q     <= 1'b0;
         acq_by_pin_q       <= 1'b0;
         acq_by_sclk_q      <= 1'b0;
         start_pin_analog_q <= 1'b1;
         second_ref_pin_analog_q      <= 1'b1;
         adc_int_ref_q      <= 1'b1;
         dac_int_ref_q      <= 1'b0;
      end else begin
         conv_clk_ext_q     <= ext_mode;
         acq_by_sclk_q      <= ext_mode;
         acq_by_pin_q       <= (clk_mode_q == 2'h1);
         start_pin_analog_q <= clk_mode_q[1];
         second_ref_pin_analog_q      <= ~ref_mode_q[0];
         adc_int_ref_q      <= ~ref_mode_q[0];
         dac_int_ref_q      <= (ref_mode_q == 2'h0);
      end
   end

   // internal conversion clock divider
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         div_q      <= 8'h00;
         int_tick_q <= 1'b0;
      end else begin
         div_q      <= (div_q == DIV_LAST) ? 8'h00 : 8'(div_q + 8'h01);
         int_tick_q <= (div_q == DIV_LAST);
      end
   end

   // pending temperature request, set wins over the clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         temp_req_q <= 1'b0;
      end else if (byte_done && is_conv) begin
         temp_req_q <= rx_byte[`ASC_TEMP_BIT];
      end else if (st_q == asc_pkg::S_IDLE && scan_req) begin
         temp_req_q <= 1'b0;
      end
   end

   // sequencer next state and timer loads
   always_comb begin
      st_d   = st_q;
      ld     = 1'b0;
      ld_val = 8'h00;
      case (st_q)
         asc_pkg::S_IDLE: begin
            if (scan_req && temp_now) begin
               st_d   = asc_pkg::S_TEMP_WAIT;
               ld     = 1'b1;
               ld_val = `ASC_REF_WAKE_CYC;
            end else if (scan_req && !ref_mode_q[0] && !int_ref_pwr_q) begin
               st_d   = asc_pkg::S_REF_WAIT;
               ld     = 1'b1;
               ld_val = `ASC_REF_ON_CYC;
            end else if (scan_req) begin
               st_d   = asc_pkg::S_CONVERT;
            end
         end
         asc_pkg::S_TEMP_WAIT: begin
            if (expired && ext_mode) begin
               st_d   = asc_pkg::S_TEMP_OUT;
               ld     = 1'b1;
               ld_val = `ASC_TEMP_OUT_CYC;
            end else if (expired) begin
               st_d   = asc_pkg::S_CONVERT;
            end
         end
         asc_pkg::S_TEMP_OUT: begin
            if (expired) begin
               st_d = asc_pkg::S_CONVERT;
            end
         end
         asc_pkg::S_REF_WAIT: begin
            if (expired) begin
               st_d = asc_pkg::S_CONVERT;
            end
         end
         asc_pkg::S_CONVERT: begin
            if (scan_done) begin
               st_d = asc_pkg::S_IDLE;
            end
         end
         default: begin
            st_d = asc_pkg::S_IDLE;
         end
      endcase
   end

   // sequencer state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= asc_pkg::S_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // sequencer outputs and reference power
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         int_ref_pwr_q <= 1'b0;
         conv_go_q     <= 1'b0;
         temp_go_q     <= 1'b0;
         busy_q        <= 1'b0;
      end else begin
         if (ld && st_q == asc_pkg::S_IDLE) begin
            int_ref_pwr_q <= 1'b1;
         end else if (st_q == asc_pkg::S_CONVERT && scan_done) begin
            int_ref_pwr_q <= 1'b0;
         end
         conv_go_q <= (st_d == asc_pkg::S_CONVERT)
            && (st_q != asc_pkg::S_CONVERT);
         temp_go_q <= expired && ((st_q == asc_pkg::S_TEMP_OUT)
            || (st_q == asc_pkg::S_TEMP_WAIT && !ext_mode));
         busy_q    <= (st_d != asc_pkg::S_IDLE);
      end
   end

   // wake-up delay timer
   asc_tick_timer #(
      .W        (8)
   ) u_timer (
      .clock    (clock),
      .rst_n    (rst_n),
      .load     (ld),
      .load_val (ld_val),
      .tick     (tick),
      .expired  (expired)
   );

   // ticks counted in the current state, checking only
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hlp_q <= 8'h00;
      end else if (st_d != st_q) begin
         hlp_q <= 8'h00;
      end else begin
         hlp_q <= 8'(hlp_q + {7'h00, tick});
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // leaving a wait state
   sequence s_leave(asc_pkg::asc_state_t s);
      st_q == s && st_d != s;
   endsequence

   // entering temperature wait from idle
   sequence s_temp_entry;
      st_q == asc_pkg::S_IDLE ##1 st_q == asc_pkg::S_TEMP_WAIT;
   endsequence

   a_setup_decode: assert property (
      byte_done && is_setup |=> clk_mode_q == $past(rx_byte[5:4])
         && ref_mode_q == $past(rx_byte[3:2]))
      else $error("setup fields not loaded");

   a_pair_write: assert property (
      byte_done && exp_q && pair_sel_q == `ASC_PAIR_UNI
         |=> unipolar_q == $past(rx_byte) && $stable(bipolar_q))
      else $error("unipolar register not written");

   a_start_pin_cfg: assert property (
      ##1 start_pin_analog_q == $past(clk_mode_q[1]))
      else $error("shared start pin function wrong");

   a_second_ref_pin_cfg: assert property (
      ##1 second_ref_pin_analog_q == ($past(ref_mode_q[0]) == 1'b0))
      else $error("second reference pin function wrong");

   a_ref_on_218: assert property (
      s_leave(asc_pkg::S_REF_WAIT) |-> hlp_q == `ASC_REF_ON_CYC)
      else $error("reference on delay not 218 ticks");

   a_ref_wake_244: assert property (
      s_leave(asc_pkg::S_TEMP_WAIT) |-> hlp_q == `ASC_REF_WAKE_CYC)
      else $error("temperature settle not 244 ticks");

   a_temp_out_188: assert property (
      s_leave(asc_pkg::S_TEMP_OUT) |-> hlp_q == `ASC_TEMP_OUT_CYC
         ##1 temp_go_q)
      else $error("temperature result not after 188 ticks");

   a_temp_power: assert property (
      s_temp_entry |-> int_ref_pwr_q)
      else $error("reference not powered for temperature");

   a_scan_start: assert property (
      reg_start && st_q == asc_pkg::S_IDLE |=> busy_q ##[0:1] conv_go_q
         || st_q != asc_pkg::S_CONVERT)
      else $error("conversion write did not start scan");

   a_ref_off: assert property (
      st_q == asc_pkg::S_CONVERT && scan_done |=> !int_ref_pwr_q
         && st_q == asc_pkg::S_IDLE)
      else $error("reference not off after scan");

endmodule // asc_setup_ctrl

// >>> core/asc_consts.svh
// constants for the adc setup, clock-mode and reference-mode control
// assumes it is included by bare name from core/ design files
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

// command byte decode
`define ASC_SEL_SETUP    2'h1   // bits 7:6 of a setup command byte
`define ASC_CONV_SEL     7      // bit 7 set selects the conversion register
`define ASC_TEMP_BIT     0      // temperature request bit, conversion byte
`define ASC_CLK_HI       5      // clock-mode field, upper bit
`define ASC_CLK_LO       4      // clock-mode field, lower bit
`define ASC_REF_HI       3      // reference-mode field, upper bit
`define ASC_REF_LO       2      // reference-mode field, lower bit
`define ASC_PAIR_HI      1      // pair-register select, upper bit
`define ASC_PAIR_LO      0      // pair-register select, lower bit

// field encodings
`define ASC_MODE_EXT     2'h3   // clock mode 11, serial clock converts
`define ASC_PAIR_UNI     2'h2   // next byte goes to unipolar register
`define ASC_PAIR_BIP     2'h3   // next byte goes to bipolar register

// reset values
`define ASC_CLK_MODE_RST 2'h2   // upper clock-mode bit set at power-up
`define ASC_REF_MODE_RST 2'h2   // default reference mode 10
`define ASC_PAIR_RST     2'h0   // no data byte expected
`define ASC_PAIR_REG_RST 8'h00  // all pairs unipolar single-ended

// reference and temperature delays, in conversion-clock cycles
`define ASC_REF_ON_CYC   8'hDA  // 218 cycles after reference wake-up
`define ASC_REF_WAKE_CYC 8'hF4  // 244 cycles reference settle, temperature
`define ASC_TEMP_OUT_CYC 8'hBC  // 188 further cycles in clock mode 11

`endif

// >>> core/asc_pkg.sv
// types shared by the adc setup and reference control
// assumes nothing of its surroundings
package asc_pkg;

   // scan sequencing states
   typedef enum logic [2:0] {
      S_IDLE,
      S_TEMP_WAIT,
      S_TEMP_OUT,
      S_REF_WAIT,
      S_CONVERT
   } asc_state_t;

endpackage

// >>> core/asc_tick_timer.sv
// down counter of conversion-clock ticks with a one-cycle expiry pulse
// assumes tick is a one-cycle pulse on the clock domain, never back to back
`timescale 1ns/1ps
module asc_tick_timer #(
   parameter int W = 8                     // counter width
) (
   input  wire logic         clock,        // system clock
   input  wire logic         rst_n,        // async reset, active low
   input  wire logic         load,         // start a new count
   input  wire logic [W-1:0] load_val,     // ticks to wait
   input  wire logic         tick,         // one conversion-clock tick
   output logic              expired       // pulse after last tick
);

   logic [W-1:0] cnt_q;                    // ticks still to wait

   // count down, load wins over a tick
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= load_val;
      end else if (tick && cnt_q != '0) begin
         cnt_q <= cnt_q - W'(1);
      end
   end

   // pulse once when the final tick lands
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         expired <= 1'b0;
      end else begin
         expired <= !load && tick && (cnt_q == W'(1));
      end
   end

endmodule // asc_tick_timer

// >>> test/asc_host_model.sv
// serial host model: drives the serial pins and the start pin
// assumes a mode 0 slave sampling data on the rising serial clock edge
`timescale 1ns/1ps
module asc_host_model (
   input  wire logic clock,          // system clock, paces pin changes
   output logic      sclk_pin,       // serial clock, low when not pulsed
   output logic      cs_n_pin,       // chip select, low active
   output logic      mosi_pin,       // serial data, msb first
   output logic      conv_start_pin  // conversion start, idle high
);
   // idle pins at time zero
   initial begin
      sclk_pin = 1'b0;
      cs_n_pin = 1'b1;
      mosi_pin = 1'b0;
      conv_start_pin = 1'b1;
   end

   // wait n clocks, then step just past the edge
   task automatic gap(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // one byte, msb first, 32 ns high and low
   task automatic shift_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         mosi_pin = b[i];
         gap(4);
         sclk_pin = 1'b1;
         gap(4);
         sclk_pin = 1'b0;
      end
   endtask

   // frame edges; released data line shows the inverse of its last bit
   task automatic open_frame();
      cs_n_pin = 1'b0;
      gap(4);
   endtask

   task automatic close_frame();
      gap(4);
      cs_n_pin = 1'b1;
      mosi_pin = ~mosi_pin;
      gap(4);
   endtask

   // single command byte; setup bytes carry 01 in bits 7:6
   task automatic frame1(input logic [7:0] b);
      open_frame();
      shift_byte(b);
      close_frame();
   endtask

   // command plus data byte held in one frame
   task automatic frame2(input logic [15:0] w);
      open_frame();
      shift_byte(w[15:8]);
      shift_byte(w[7:0]);
      close_frame();
   endtask

   // conversion clocks outside frames, 288 ns period stays under 3.6 MHz
   task automatic run_clocks(input int n);
      repeat (n) begin
         sclk_pin = 1'b1;
         gap(18);
         sclk_pin = 1'b0;
         gap(18);
      end
   endtask

   // low pulse on the start pin
   task automatic start_pulse();
      conv_start_pin = 1'b0;
      gap(8);
      conv_start_pin = 1'b1;
      gap(8);
   endtask
endmodule // asc_host_model

// >>> test/testbench.sv
// self-checking bench for the setup decode and reference sequencing
// assumes the host model owns all serial and start pins
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   n_errors++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
   logic       clock;                // system clock
   logic       rst_n;                // reset, active low
   logic       scan_done;            // converter done pulse
   logic       sclk;                 // serial clock pin
   logic       cs_n;                 // chip select pin
   logic       mosi;                 // serial data pin
   logic       cstart;               // conversion-start pin
   logic [1:0] clk_mode_q;           // clock-mode field
   logic [1:0] ref_mode_q;           // reference-mode field
   logic [1:0] pair_sel_q;           // pair select field
   logic [7:0] unipolar_q;           // unipolar pair register
   logic [7:0] bipolar_q;            // bipolar pair register
   logic       ext_q;                // conversion clock external
   logic       by_pin_q;             // acquisition by start pin
   logic       by_sclk_q;            // sampling by serial clock
   logic       pin_an_q;             // start pin is analog
   logic       second_ref_pin_an_q;            // second ref pin is analog
   logic       adc_ir_q;             // adc internal reference
   logic       dac_ir_q;             // dac internal reference
   logic       pwr_q;                // internal reference powered
   logic       conv_go_q;            // analog scan start pulse
   logic       temp_go_q;            // temperature pulse
   logic       busy_q;               // sequencer busy
   int         n_errors = 0;         // mismatches
   int         samples_checked = 0;  // comparisons
   int         cyc;                  // cycles since busy rose
   int         conv_at;              // cyc at analog start
   int         temp_at;              // cyc at temperature pulse
   int         n_conv;               // analog starts seen
   int         n_temp;               // temperature pulses seen

   asc_host_model i_host (
      .clock          (clock),
      .sclk_pin       (sclk),
      .cs_n_pin       (cs_n),
      .mosi_pin       (mosi),
      .conv_start_pin (cstart)
   );

   asc_setup_ctrl #(
      .INT_DIV (4)
   ) i_dut (
      .clock              (clock),
      .rst_n              (rst_n),
      .sclk_pin           (sclk),
      .cs_n_pin           (cs_n),
      .mosi_pin           (mosi),
      .conv_start_pin     (cstart),
      .scan_done          (scan_done),
      .clk_mode_q         (clk_mode_q),
      .ref_mode_q         (ref_mode_q),
      .pair_sel_q         (pair_sel_q),
      .unipolar_q         (unipolar_q),
      .bipolar_q          (bipolar_q),
      .conv_clk_ext_q     (ext_q),
      .acq_by_pin_q       (by_pin_q),
      .acq_by_sclk_q      (by_sclk_q),
      .start_pin_analog_q (pin_an_q),
      .second_ref_pin_analog_q      (second_ref_pin_an_q),
      .adc_int_ref_q      (adc_ir_q),
      .dac_int_ref_q      (dac_ir_q),
      .int_ref_pwr_q      (pwr_q),
      .conv_go_q          (conv_go_q),
      .temp_go_q          (temp_go_q),
      .busy_q             (busy_q)
   );

   // 125 MHz clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // pulse monitor, timing measured from busy rising
   always @(posedge clock) begin
      cyc <= (busy_q === 1'b1) ? cyc + 1 : 0;
      if (conv_go_q === 1'b1) begin
         n_conv <= n_conv + 1;
         conv_at <= cyc;
      end
      if (temp_go_q === 1'b1) begin
         n_temp <= n_temp + 1;
         temp_at <= cyc;
      end
   end

   // counts, verdict, end of run
   task automatic summarize();
      $display("errors %0d of %0d checks", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // all decoded configuration flags against a mode pair
   task automatic chk_cfg(input logic [1:0] cm, input logic [1:0] rm);
      `CHK(clk_mode_q, cm);
      `CHK(ref_mode_q, rm);
      `CHK(ext_q, cm == 2'h3);
      `CHK(by_sclk_q, cm == 2'h3);
      `CHK(by_pin_q, cm == 2'h1);
      `CHK(pin_an_q, cm[1]);
      `CHK(second_ref_pin_an_q, !rm[0]);
      `CHK(adc_ir_q, !rm[0]);
      `CHK(dac_ir_q, rm == 2'h0);
   endtask

   // clear pulse counters before a scan
   task automatic clr();
      n_conv = 0;
      n_temp = 0;
   endtask

   // bounded wait for the analog start pulse
   task automatic wait_conv(input int lim);
      int k;
      k = 0;
      while (n_conv == 0) begin
         if (k++ >= lim) begin
            n_errors++;
            summarize();
         end
         i_host.gap(1);
      end
   endtask

   // converter reports the scan finished
   task automatic finish_scan();
      scan_done = 1'b1;
      i_host.gap(1);
      scan_done = 1'b0;
      i_host.gap(2);
      `CHK(busy_q, 1'b0);
      `CHK(pwr_q, 1'b0);
   endtask

   // main sequence
   initial begin
      rst_n = 1'b0;
      scan_done = 1'b0;
      clr();
      i_host.gap(16);
      rst_n = 1'b1;
      i_host.gap(4);
      chk_cfg(2'h2, 2'h2);
      `CHK(pair_sel_q, 2'h0);
      `CHK({unipolar_q, bipolar_q}, 16'h0000);
      // every clock mode with every reference mode
      for (int m = 0; m < 16; m++) begin
         i_host.frame1({2'h1, m[3:0], 2'h0});
         chk_cfg(m[3:2], m[1:0]);
      end
      // bits 7:6 = 00 is another register: fields keep their values
      i_host.frame1(8'h20);
      chk_cfg(2'h3, 2'h3);
      // pair registers loaded by the byte after the setup byte
      i_host.frame2({8'h6E, 8'hA5});
      `CHK(pair_sel_q, 2'h2);
      `CHK(unipolar_q, 8'hA5);
      i_host.frame2({8'h6F, 8'h5A});
      `CHK({unipolar_q, bipolar_q}, 16'hA55A);
      i_host.frame2({8'h45, 8'h68});
      chk_cfg(2'h2, 2'h2);
      i_host.frame1(8'h6A);
      i_host.frame1(8'h53);
      chk_cfg(2'h1, 2'h0);
      `CHK({unipolar_q, bipolar_q}, 16'hA55A);
      // mode 01: conversion byte ignored, start pin starts the scan
      i_host.frame1(8'h80);
      i_host.gap(20);
      `CHK(busy_q, 1'b0);
      i_host.start_pulse();
      wait_conv(2000);
      `CHK(conv_at inside {[866:884]}, 1'b1);
      finish_scan();
      // mode 00 external reference: start pin, no wake-up wait
      i_host.frame1(8'h4C);
      clr();
      i_host.start_pulse();
      wait_conv(50);
      `CHK(conv_at < 4, 1'b1);
      finish_scan();
      // mode 10 external reference: start pin is analog, no wait
      i_host.frame1(8'h64);
      i_host.start_pulse();
      `CHK(busy_q, 1'b0);
      clr();
      i_host.frame1(8'h80);
      wait_conv(50);
      `CHK(conv_at < 4, 1'b1);
      `CHK(pwr_q, 1'b0);
      finish_scan();
      // temperature powers the reference and waits 244 ticks
      clr();
      i_host.frame1(8'h81);
      wait_conv(2000);
      `CHK(temp_at inside {[970:986]}, 1'b1);
      `CHK(pwr_q, 1'b1);
      finish_scan();
      // mode 11 reference 10: 218 serial clocks
      i_host.frame1(8'h78);
      clr();
      i_host.frame1(8'h80);
      i_host.run_clocks(217);
      i_host.gap(8);
      `CHK(n_conv, 0);
      i_host.run_clocks(1);
      i_host.gap(8);
      `CHK(n_conv, 1);
      finish_scan();
      // mode 11 temperature: 244 plus 188 serial clocks
      clr();
      i_host.frame1(8'h81);
      i_host.run_clocks(431);
      i_host.gap(8);
      `CHK(n_temp, 0);
      `CHK(pwr_q, 1'b1);
      i_host.run_clocks(1);
      i_host.gap(8);
      `CHK(n_temp, 1);
      i_host.run_clocks(2);
      wait_conv(50);
      finish_scan();
      summarize();
   end
endmodule // testbench
